// ==== design/bcc_pkg.sv ====
// ==========================================================
// shared types and constants of the converter control block
package bcc_pkg;

    // ==========================================================
    // timing
    localparam int unsigned SYS_CLK_HZ    = 40_000_000;
    localparam int unsigned SYS_PERIOD_PS = 1_000_000_000 / (SYS_CLK_HZ / 1000);
    localparam int unsigned MIN_PULSE_WIDTH_SELECT_A_NS    = 10;
    localparam int unsigned MIN_PULSE_WIDTH_SELECT_B_NS    = 20;
    localparam int unsigned MIN_PULSE_WIDTH_SELECT_C_NS    = 40;
    // least times round up to whole cycles
    localparam int unsigned MIN_PULSE_WIDTH_SELECT_A_CYC = (MIN_PULSE_WIDTH_SELECT_A_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
    localparam int unsigned MIN_PULSE_WIDTH_SELECT_B_CYC = (MIN_PULSE_WIDTH_SELECT_B_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
    localparam int unsigned MIN_PULSE_WIDTH_SELECT_C_CYC = (MIN_PULSE_WIDTH_SELECT_C_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;

    // ==========================================================
    // output level: millivolts = base + step * code
    localparam logic [11:0] LEVEL_BASE_MV = 12'h708;  // 1800
    localparam logic [11:0] LEVEL_STEP_MV = 12'h064;  // 100

    // ==========================================================
    // peak current limit table, mA
    localparam logic [9:0] LIMIT_MA_1 = 10'h0C8;  // 200
    localparam logic [9:0] LIMIT_MA_2 = 10'h12C;  // 300
    localparam logic [9:0] LIMIT_MA_3 = 10'h190;  // 400
    localparam logic [9:0] LIMIT_MA_4 = 10'h1F4;  // 500
    localparam logic [9:0] LIMIT_MA_5 = 10'h258;  // 600
    localparam logic [9:0] LIMIT_MA_NONE = 10'h000;

    // ==========================================================
    // values after reset
    localparam logic [3:0] RST_LEVEL_SEL = 4'h1;  // 1.9 V
    localparam logic [2:0] RST_LIMIT_SEL = 3'h4;  // 500 mA
    localparam logic [1:0] RST_MIN_PW    = 2'h3;  // 40 ns
    localparam logic       RST_SW_LARGE  = 1'h1;
    localparam logic [1:0] RST_CLK_DIV   = 2'h0;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        BCC_OFF   = 3'h1,
        BCC_START = 3'h2,
        BCC_RUN   = 3'h4
    } bcc_mode_t;

    typedef struct packed {
        logic       convEnable;        // converter_enable_bit
        logic [3:0] levelSel;          // output_level_select
        logic [2:0] limitSel;          // peak_current_limit_select
        logic [1:0] minPwSel;          // min_pulse_width_select
        logic       switchLarge;       // 1 = large switches
        logic       clkSrcSys;         // converter_clock_source_select
        logic [1:0] converter_clock_divider;            // converter_clock_divider
        logic       clkInvert;         // divider_input_invert
        logic       forcedBypass;      // forced_bypass_bit
        logic       autoBypassEn;      // auto_bypass_enable
    } bcc_cfg_t;

    // comparator levels from the analog section, asynchronous
    typedef struct packed {
        logic readyHigh;    // rail within window, upper comparator
        logic readyLow;     // rail within window, lower comparator
        logic overCurrent;  // peak inductor current above limit
        logic overVoltage;  // rail above programmed target
        logic marginLow;    // input exceeds output by under 0.4 V
        logic marginHigh;   // input exceeds output by over 0.5 V
    } bcc_ana_t;

    typedef struct packed {
        logic readyHigh;    // output_ready_high_flag
        logic readyLow;     // output_ready_low_flag
        logic bypassClosed; // bypass indicator
        logic skipping;     // last switching cycle was skipped as too short
        logic limiting;     // switching curtailed
        logic starting;     // start-up charge in progress
    } bcc_status_t;

endpackage

// ==== design/bcc_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// two-stage synchroniser for a group of asynchronous levels
module bcc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,  // system clock
    input  wire logic             rstn,     // sync reset, low
    input  wire logic [WIDTH-1:0] asyncIn,  // raw levels
    output logic      [WIDTH-1:0] syncOut   // settled levels
);
    import bcc_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } bcc_sync_state_t;

    bcc_sync_state_t st_reg;
    bcc_sync_state_t st_next;

    // shift through two flops
    always_comb begin
        st_next        = st_reg;
        st_next.stage1 = asyncIn;
        st_next.stage2 = st_reg.stage1;
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign syncOut = st_reg.stage2;
endmodule
`default_nettype wire

// ==== design/bcc_control.sv ====
`timescale 1ns/100ps
`default_nettype none
module bcc_control (
    input  wire logic                 sys_clk,         // 40 MHz system clock
    input  wire logic                 rstn,            // sync reset, low
    input  wire logic                 cfgWrite,        // load cfgIn
    input  wire bcc_pkg::bcc_cfg_t    cfgIn,           // new configuration
    input  wire logic [7:0]           onTimeReq,       // demanded on time, cycles
    input  wire logic                 oscIn,           // internal oscillator
    input  wire bcc_pkg::bcc_ana_t    anaIn,           // analog comparators
    output logic                      highSideSwitch,  // high_side_switch gate
    output logic                      bypassSwitch,    // bypass_switch gate
    output logic                      largeSwitchSel,  // 1 = large switches
    output logic [3:0]                levelCode,       // level code to reference
    output logic [11:0]               levelMv,         // programmed level, mV
    output logic [2:0]                limitCode,       // limit code to analog
    output logic [9:0]                limitMa,         // peak limit, mA
    output logic                      convClkTick,     // one pulse per switch cycle
    output bcc_pkg::bcc_cfg_t         cfgOut,          // configuration readback
    output bcc_pkg::bcc_status_t      status           // read-only status
);
    import bcc_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        bcc_cfg_t    cfg;
        bcc_mode_t   mode;
        logic [2:0]  divCnt;
        logic        oscPrev;
        logic [7:0]  onCnt;
        logic        highSide;
        logic        bypass;
        logic        autoHold;
        logic        tick;
        logic [11:0] levelMv;
        logic [9:0]  limitMa;
        bcc_status_t status;
    } bcc_state_t;

    localparam bcc_cfg_t CFG_RESET = '{
        convEnable:   1'h0,
        levelSel:     RST_LEVEL_SEL,
        limitSel:     RST_LIMIT_SEL,
        minPwSel:     RST_MIN_PW,
        switchLarge:  RST_SW_LARGE,
        clkSrcSys:    1'h0,
        converter_clock_divider:       RST_CLK_DIV,
        clkInvert:    1'h0,
        forcedBypass: 1'h0,
        autoBypassEn: 1'h0
    };

    // reset image of the whole state; level and limit agree with the reset codes
    localparam bcc_state_t ST_RESET = '{
        cfg:      CFG_RESET,
        mode:     BCC_OFF,
        divCnt:   3'h0,
        oscPrev:  1'h0,
        onCnt:    8'h00,
        highSide: 1'h0,
        bypass:   1'h0,
        autoHold: 1'h0,
        tick:     1'h0,
        levelMv:  12'(LEVEL_BASE_MV + LEVEL_STEP_MV * 12'(RST_LEVEL_SEL)),
        limitMa:  LIMIT_MA_4,
        status:   '0
    };

    // least widths in whole cycles, rounded up so a pulse is never too narrow
    localparam logic [7:0] MIN_PULSE_WIDTH_SELECT_A = 8'(MIN_PULSE_WIDTH_SELECT_A_CYC);
    localparam logic [7:0] MIN_PULSE_WIDTH_SELECT_B = 8'(MIN_PULSE_WIDTH_SELECT_B_CYC);
    localparam logic [7:0] MIN_PULSE_WIDTH_SELECT_C = 8'(MIN_PULSE_WIDTH_SELECT_C_CYC);

    bcc_state_t st_reg;
    bcc_state_t st_next;

    // ==========================================================
    // synchronisers for the asynchronous inputs
    logic [6:0] rawIn;
    logic [6:0] syncIn;
    logic       oscS;
    bcc_ana_t   anaS;

    // oscillator and comparators pass two flops first
    // comparators move with the rail at any time, so a raw level
    // read straight into the sequencer could go metastable
    // the oscillator shares the chain, so its ticks lag two cycles
    assign rawIn = {oscIn, anaIn};

    bcc_sync #(
        .WIDTH   (7)
    ) u_sync (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .asyncIn (rawIn),
        .syncOut (syncIn)
    );

    assign oscS = syncIn[6];
    assign anaS = bcc_ana_t'(syncIn[5:0]);

    // ==========================================================
    // next-state logic
    logic [2:0] divMax;
    logic [2:0] divPhase;
    logic       sysTick;
    logic       oscRise;
    logic       swTick;
    logic       curtail;
    logic [7:0] min_pulse_width_select;
    logic       pulseTooShort;

    always_comb begin
        st_next = st_reg;

        // configuration load
        // a write lands in one cycle; every decoded output follows the new copy
        if (cfgWrite) begin
            st_next.cfg = cfgIn;
        end

        // ==========================================================
        // switching clock
        // system clock divider, period 1, 2, 4 or 8 cycles
        case (st_reg.cfg.converter_clock_divider)
            2'h0:    divMax = 3'h0;
            2'h1:    divMax = 3'h1;
            2'h2:    divMax = 3'h3;
            default: divMax = 3'h7;
        endcase
        // inverted input moves the divided edge by half a period
        // sum is one bit wider so divide by eight gives phase four
        // limitation: no shift is possible at divide by one
        divPhase = st_reg.cfg.clkInvert ? 3'((4'(divMax) + 4'h1) >> 1) : 3'h0;
        st_next.divCnt = (st_reg.divCnt >= divMax) ? 3'h0 : 3'(st_reg.divCnt + 3'h1);
        sysTick = (st_reg.divCnt == divPhase);

        // oscillator rising edge from the settled stage
        oscRise = oscS & ~st_reg.oscPrev;
        st_next.oscPrev = oscS;

        // switching clock source; divider ignored on oscillator
        swTick = st_reg.cfg.clkSrcSys ? sysTick : oscRise;
        st_next.tick = swTick;

        // ==========================================================
        // protection and pulse width
        // protection stops switching at once
        curtail = anaS.overCurrent | anaS.overVoltage;
        st_next.status.limiting = curtail;

        // minimum pulse width in cycles, zero means off
        case (st_reg.cfg.minPwSel)
            2'h0:    min_pulse_width_select = 8'h00;
            2'h1:    min_pulse_width_select = MIN_PULSE_WIDTH_SELECT_A;
            2'h2:    min_pulse_width_select = MIN_PULSE_WIDTH_SELECT_B;
            default: min_pulse_width_select = MIN_PULSE_WIDTH_SELECT_C;
        endcase
        pulseTooShort = (min_pulse_width_select != 8'h00) && (onTimeReq < min_pulse_width_select);

        // ==========================================================
        // converter sequencing
        case (st_reg.mode)
            BCC_OFF: begin
                // drop any stale pulse so a restart begins with a full charge
                st_next.onCnt = 8'h00;
                st_next.highSide = 1'h0;
                st_next.status.starting = 1'h0;
                if (st_reg.cfg.convEnable) begin
                    st_next.mode = BCC_START;
                    st_next.status.starting = 1'h1;
                    st_next.highSide = ~curtail;
                end
            end
            BCC_START: begin
                // charge until the rail reaches its level
                st_next.highSide = ~curtail;
                if (!st_reg.cfg.convEnable) begin
                    st_next.mode = BCC_OFF;
                    st_next.highSide = 1'h0;
                    st_next.status.starting = 1'h0;
                end else if (anaS.overVoltage) begin
                    st_next.mode = BCC_RUN;
                    st_next.highSide = 1'h0;
                    st_next.status.starting = 1'h0;
                end
            end
            BCC_RUN: begin
                // count down the current pulse
                if (st_reg.onCnt != 8'h00) begin
                    st_next.onCnt = 8'(st_reg.onCnt - 8'h01);
                end
                // new cycle: emit full pulse or skip it entirely
                if (swTick) begin
                    if (onTimeReq == 8'h00 || curtail) begin
                        st_next.onCnt = 8'h00;
                        st_next.status.skipping = 1'h0;
                    end else if (pulseTooShort) begin
                        st_next.onCnt = 8'h00;
                        st_next.status.skipping = 1'h1;
                    end else begin
                        st_next.onCnt = onTimeReq;
                        st_next.status.skipping = 1'h0;
                    end
                end
                // curtail wins over a new pulse, so an overdriven rail is never pushed
                if (curtail) begin
                    st_next.onCnt = 8'h00;
                end
                st_next.highSide = (st_next.onCnt != 8'h00);
                if (!st_reg.cfg.convEnable) begin
                    st_next.mode = BCC_OFF;
                    st_next.onCnt = 8'h00;
                    st_next.highSide = 1'h0;
                    st_next.status.skipping = 1'h0;
                end
            end
            default: begin
                st_next.mode = BCC_OFF;
                st_next.onCnt = 8'h00;
                st_next.highSide = 1'h0;
            end
        endcase

        // ==========================================================
        // bypass control
        // automatic bypass hold with hysteresis
        // marginLow wins when both are high, so a shrinking margin closes first
        if (!st_reg.cfg.autoBypassEn) begin
            st_next.autoHold = 1'h0;
        end else if (anaS.marginLow) begin
            st_next.autoHold = 1'h1;
        end else if (anaS.marginHigh) begin
            st_next.autoHold = 1'h0;
        end

        // bypass gate, independent of the converter mode
        st_next.bypass = st_reg.cfg.forcedBypass | st_reg.autoHold;
        st_next.status.bypassClosed = st_next.bypass;

        // ==========================================================
        // status and decoded readback
        // ready flags from the settled comparators
        st_next.status.readyHigh = anaS.readyHigh;
        st_next.status.readyLow = anaS.readyLow;

        // programmed level in mV
        st_next.levelMv = 12'(LEVEL_BASE_MV + LEVEL_STEP_MV * {8'h00, st_next.cfg.levelSel});

        // peak current limit decode
        case (st_next.cfg.limitSel)
            3'h1:    st_next.limitMa = LIMIT_MA_1;
            3'h2:    st_next.limitMa = LIMIT_MA_2;
            3'h3:    st_next.limitMa = LIMIT_MA_3;
            3'h4:    st_next.limitMa = LIMIT_MA_4;
            3'h5:    st_next.limitMa = LIMIT_MA_5;
            default: st_next.limitMa = LIMIT_MA_NONE;
        endcase
    end

    // ==========================================================
    // state register
    // synchronous reset; the synchroniser clears on the same edges
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // outputs, all straight from the state register
    assign highSideSwitch = st_reg.highSide;
    assign bypassSwitch   = st_reg.bypass;
    assign largeSwitchSel = st_reg.cfg.switchLarge;
    assign levelCode      = st_reg.cfg.levelSel;
    assign levelMv        = st_reg.levelMv;
    assign limitCode      = st_reg.cfg.limitSel;
    assign limitMa        = st_reg.limitMa;
    assign convClkTick    = st_reg.tick;
    assign cfgOut         = st_reg.cfg;
    assign status         = st_reg.status;
endmodule
`default_nettype wire

// ==== bench/bcc_control_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========
// port-level checks on the converter control block
module bcc_control_monitor (
    input wire logic                 sys_clk,        // clock
    input wire logic                 rstn,           // reset, low
    input wire logic                 cfgWrite,       // load strobe
    input wire bcc_pkg::bcc_cfg_t    cfgIn,          // new config
    input wire bcc_pkg::bcc_ana_t    anaIn,          // comparators
    input wire logic                 highSideSwitch, // high-side gate
    input wire logic                 bypassSwitch,   // bypass gate
    input wire logic [3:0]           levelCode,      // level code
    input wire logic [11:0]          levelMv,        // level, mV
    input wire logic [2:0]           limitCode,      // limit code
    input wire logic [9:0]           limitMa,        // limit, mA
    input wire bcc_pkg::bcc_cfg_t    cfgOut,         // config readback
    input wire bcc_pkg::bcc_status_t status          // status
);
    import bcc_pkg::*;
    // ==========
    // all checks on the system clock, off during reset
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    a_cfg_load: assert property (cfgWrite |=> cfgOut == $past(cfgIn))
        else $error("config readback differs from last write");
    a_level_map: assert property (levelCode == cfgOut.levelSel &&
        levelMv == LEVEL_BASE_MV + LEVEL_STEP_MV * 12'(levelCode))
        else $error("level millivolts do not match level code");
    a_limit_map: assert property (limitMa ==
        ((limitCode inside {[1:5]}) ? 10'(100 + 100 * limitCode) : 10'h000))
        else $error("peak limit does not match limit code");
    a_ready_sync: assert property ($past(rstn, 1) && $past(rstn, 2) && $past(rstn, 3)
        |-> {status.readyHigh, status.readyLow} == $past({anaIn.readyHigh, anaIn.readyLow}, 3))
        else $error("ready flags do not follow comparators");
    a_bypass_flag: assert property (status.bypassClosed == bypassSwitch)
        else $error("bypass indicator differs from gate");
    a_forced_close: assert property (cfgOut.forcedBypass |=> bypassSwitch)
        else $error("forced bypass did not close switch");
    a_bypass_open: assert property ((!cfgOut.forcedBypass && !cfgOut.autoBypassEn)[*3]
        |=> !bypassSwitch)
        else $error("bypass closed with both sources off");
    a_auto_close: assert property ((cfgOut.autoBypassEn && anaIn.marginLow)[*5]
        |=> bypassSwitch)
        else $error("auto bypass did not close on low margin");
    a_auto_open: assert property ((cfgOut.autoBypassEn && !cfgOut.forcedBypass
        && anaIn.marginHigh && !anaIn.marginLow)[*6] |=> !bypassSwitch)
        else $error("auto bypass did not reopen on high margin");
    a_curtail: assert property ((anaIn.overCurrent || anaIn.overVoltage)[*4]
        |=> !highSideSwitch)
        else $error("switching not stopped on over limit");
    a_off_idle: assert property ((!cfgOut.convEnable)[*2] |-> !highSideSwitch)
        else $error("high-side gate on while disabled");
endmodule

bind bcc_control bcc_control_monitor mon_u (.sys_clk, .rstn, .cfgWrite, .cfgIn, .anaIn,
    .highSideSwitch, .bypassSwitch, .levelCode, .levelMv, .limitCode, .limitMa, .cfgOut,
    .status);
`default_nettype wire

// ==== bench/test_bcc_control.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========
// self-checking bench for the converter control block
module test_bcc_control;
    import bcc_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rstn;
    logic        cfgWrite;
    bcc_cfg_t    cfgIn;
    logic [7:0]  onTimeReq;
    logic        oscIn = 1'b0;
    logic [3:0]  oscCnt = 4'h0;
    bcc_ana_t    anaIn;
    logic        highSideSwitch;
    logic        bypassSwitch;
    logic        largeSwitchSel;
    logic [3:0]  levelCode;
    logic [11:0] levelMv;
    logic [2:0]  limitCode;
    logic [9:0]  limitMa;
    logic        convClkTick;
    bcc_cfg_t    cfgOut;
    bcc_status_t status;
    bcc_cfg_t    cfg;
    bcc_ana_t    ana;
    logic [7:0]  req;
    logic [23:0] n;
    int          errorCnt = 0;
    int          samplesChecked = 0;
    int          cycleCnt = 0;
    int          tickAt = -1;
    int          phaseRef = 0;
    int          tickPer = 1;
    int          pwTab[5] = '{3, 3, 2, 1, 0};
    int          reqTab[5] = '{3, 1, 1, 1, 1};
    int          hiTab[5] = '{24, 0, 8, 8, 8};

    bcc_control dut_u (.sys_clk, .rstn, .cfgWrite, .cfgIn, .onTimeReq, .oscIn, .anaIn,
        .highSideSwitch, .bypassSwitch, .largeSwitchSel, .levelCode, .levelMv, .limitCode,
        .limitMa, .convClkTick, .cfgOut, .status);

    // clock and slow internal oscillator, 16 cycles a period
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        oscCnt <= oscCnt + 4'h1;
        oscIn  <= oscCnt[3];
    end

    // ==========
    // helpers
    task automatic close_out();
        if (errorCnt == 0 && samplesChecked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        samplesChecked++;
        if (got !== exp) begin
            errorCnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // apply config, demand and comparator levels at one edge
    task automatic drive();
        @(posedge sys_clk);
        cfgWrite  <= 1'b1;
        cfgIn     <= cfg;
        onTimeReq <= req;
        anaIn     <= ana;
        @(posedge sys_clk);
        cfgWrite <= 1'b0;
    endtask
    task automatic wt(input int k);
        repeat (k) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    // high cycles of tick (sel 0) or high-side gate over 64 clocks, first tick cycle
    task automatic cnt(input int sel);
        n = 24'h000000;
        tickAt = -1;
        repeat (64) begin
            @(negedge sys_clk);
            n += (sel == 0) ? 24'(convClkTick) : 24'(highSideSwitch);
            if (convClkTick === 1'b1 && tickAt < 0)
                tickAt = cycleCnt;
        end
    endtask

    // hang guard
    always @(posedge sys_clk) begin
        cycleCnt <= cycleCnt + 1;
        if (cycleCnt == 10000) begin
            errorCnt++;
            close_out();
        end
    end

    // ==========
    // main sequence
    initial begin
        rstn = 1'b0;
        cfgWrite = 1'b0;
        cfgIn = '0;
        onTimeReq = 8'h00;
        anaIn = '0;
        ana = '0;
        req = 8'h00;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        wt(1);
        cfg = '0;
        cfg.levelSel = 4'h1;
        cfg.limitSel = 3'h4;
        cfg.minPwSel = 2'h3;
        cfg.switchLarge = 1'b1;
        chk("cfgOut", 24'(cfg), 24'(cfgOut));
        chk("levelMv", 24'h00076C, 24'(levelMv));
        chk("limitMa", 24'h0001F4, 24'(limitMa));
        chk("gates", 24'h000000, 24'({highSideSwitch, bypassSwitch}));
        for (int i = 0; i < 16; i++) begin
            cfg.levelSel = 4'(i);
            drive();
            wt(1);
            chk("levelMv", 24'(1800 + 100 * i), 24'(levelMv));
            chk("levelCode", 24'(i), 24'(levelCode));
        end
        for (int i = 0; i < 8; i++) begin
            cfg.limitSel = 3'(i);
            drive();
            wt(1);
            chk("limitMa", (i >= 1 && i <= 5) ? 24'(100 + 100 * i) : 24'h0, 24'(limitMa));
            chk("limitCode", 24'(i), 24'(limitCode));
        end
        cfg.switchLarge = 1'b0;
        drive();
        wt(1);
        chk("largeSwitchSel", 24'h0, 24'(largeSwitchSel));
        // switching clock from system clock, each divider and inversion
        cfg.clkSrcSys = 1'b1;
        for (int d = 0; d < 8; d++) begin
            cfg.converter_clock_divider = 2'(d >> 1);
            cfg.clkInvert = d[0];
            drive();
            wt(8);
            cnt(0);
            chk("ticks", 24'(64 >> (d >> 1)), n);
            // inversion must move the tick by half a divided period
            tickPer = 1 << (d >> 1);
            if (d[0] == 1'b0)
                phaseRef = tickAt;
            else
                chk("tickShift", 24'(tickPer / 2), 24'((tickAt - phaseRef) % tickPer));
        end
        // internal oscillator ignores the divider
        cfg.clkSrcSys = 1'b0;
        for (int d = 0; d < 4; d++) begin
            cfg.converter_clock_divider = 2'(d);
            drive();
            wt(8);
            cnt(0);
            chk("oscTicks", 24'h4, n);
        end
        // start-up charge ends when rail reaches level
        cfg.clkSrcSys = 1'b1;
        cfg.converter_clock_divider = 2'h3;
        cfg.clkInvert = 1'b0;
        cfg.convEnable = 1'b1;
        drive();
        wt(4);
        chk("startGate", 24'h3, 24'({highSideSwitch, status.starting}));
        ana.overVoltage = 1'b1;
        drive();
        wt(5);
        chk("startEnd", 24'h0, 24'({highSideSwitch, status.starting}));
        ana.overVoltage = 1'b0;
        // pulse width and skipping per minimum width code
        for (int i = 0; i < 5; i++) begin
            cfg.minPwSel = 2'(pwTab[i]);
            req = 8'(reqTab[i]);
            drive();
            wt(16);
            cnt(1);
            chk("highTime", 24'(hiTab[i]), n);
            chk("skipping", 24'(hiTab[i] == 0), 24'(status.skipping));
        end
        ana.overCurrent = 1'b1;
        drive();
        wt(8);
        cnt(1);
        chk("curtailed", 24'h0, n);
        chk("limiting", 24'h1, 24'(status.limiting));
        ana.overCurrent = 1'b0;
        // bypass with converter off: forced, then automatic
        cfg.convEnable = 1'b0;
        cfg.forcedBypass = 1'b1;
        drive();
        wt(3);
        chk("forcedOn", 24'h3, 24'({bypassSwitch, status.bypassClosed}));
        cfg.forcedBypass = 1'b0;
        drive();
        wt(3);
        chk("forcedOff", 24'h0, 24'({bypassSwitch, status.bypassClosed}));
        cfg.autoBypassEn = 1'b1;
        ana.marginLow = 1'b1;
        drive();
        wt(6);
        chk("autoClose", 24'h1, 24'(bypassSwitch));
        // clearing forced bypass leaves the switch to the automatic hold
        cfg.forcedBypass = 1'b1;
        drive();
        cfg.forcedBypass = 1'b0;
        drive();
        wt(3);
        chk("autoKeeps", 24'h1, 24'(bypassSwitch));
        ana.marginLow = 1'b0;
        ana.marginHigh = 1'b1;
        cfg.forcedBypass = 1'b1;
        drive();
        wt(6);
        chk("forcedHold", 24'h1, 24'(bypassSwitch));
        cfg.forcedBypass = 1'b0;
        drive();
        wt(6);
        chk("autoOpen", 24'h0, 24'(bypassSwitch));
        ana.marginHigh = 1'b0;
        ana.marginLow = 1'b1;
        cfg.autoBypassEn = 1'b0;
        drive();
        wt(6);
        chk("autoOff", 24'h0, 24'(bypassSwitch));
        // ready flags follow the comparators
        for (int i = 1; i < 3; i++) begin
            {ana.readyHigh, ana.readyLow} = 2'(i);
            drive();
            wt(4);
            chk("ready", 24'(i), 24'({status.readyHigh, status.readyLow}));
        end
        close_out();
    end
endmodule
`default_nettype wire
